// >>> cmie_defines.svh
// Purpose: constants for the misc instruction execution block
// Assumes: byte offsets on a 32-bit AXI4-Lite register bus
// Notes: vector codes and register offsets are local encodings
`ifndef CMIE_DEFINES_SVH
`define CMIE_DEFINES_SVH

// register byte offsets
`define CMIE_OFF_CMD 8'h00
`define CMIE_OFF_OPA 8'h04
`define CMIE_OFF_OPB 8'h08
`define CMIE_OFF_OPC 8'h0C
`define CMIE_OFF_PSR 8'h10
`define CMIE_OFF_RESULT 8'h14
`define CMIE_OFF_STATUS 8'h18
`define CMIE_OFF_PC 8'h1C

// command codes, CMD[3:0]
`define CMIE_OP_EA 4'h1
`define CMIE_OP_CINV 4'h2
`define CMIE_OP_CMP 4'h3
`define CMIE_OP_DI 4'h4
`define CMIE_OP_EI 4'h5
`define CMIE_OP_EIWAIT 4'h6
`define CMIE_OP_EXCP 4'h7

// PSR bit positions
`define CMIE_PSR_ZERO 0
`define CMIE_PSR_SGT 1
`define CMIE_PSR_UGT 2
`define CMIE_PSR_LOCAL 3
`define CMIE_PSR_GLOBAL 4
`define CMIE_PSR_SRCFG 5

// cache option bits in OPA
`define CMIE_CINV_I 0
`define CMIE_CINV_D 1
`define CMIE_CINV_U 2

// OPC fields for address calculation
`define CMIE_OPC_MODE_LSB 24
`define CMIE_OPC_DISP20 27
`define CMIE_OPC_PAIR_LSB 16

// address modes
`define CMIE_MODE_RELRP 3'h0
`define CMIE_MODE_IDXRP 3'h1
`define CMIE_MODE_REL 3'h2
`define CMIE_MODE_IDXABS 3'h3
`define CMIE_MODE_SHORT_ABSOLUTE 3'h4
`define CMIE_MODE_ABS24 3'h5

// short absolute remap and displacement masks
`define CMIE_SHORT_ABSOLUTE_LIMIT 24'h0EFFFF
`define CMIE_TOP_SEGMENT 24'hF00000
`define CMIE_DISP16_MASK 24'h00FFFF
`define CMIE_DISP14_MASK 24'h003FFF
`define CMIE_DISP20_MASK 24'h0FFFFF

// trap vectors
`define CMIE_VEC_SVC 4'h5
`define CMIE_VEC_DVZ 4'h6
`define CMIE_VEC_FLG 4'h7
`define CMIE_VEC_BPT 4'h8
`define CMIE_VEC_UND 4'hA

// length of the enable-and-wait instruction in bytes
`define CMIE_EIWAIT_LEN 24'h000002

// AXI responses
`define CMIE_RESP_OKAY 2'h0
`define CMIE_RESP_SLVERR 2'h2
`endif

// >>> cmie_pkg.sv
// Purpose: types for the misc instruction execution block
// Assumes: constants live in cmie_defines.svh
// Notes: none
package cmie_pkg;
   typedef struct packed {
      logic srcfg;
      logic global_gate;
      logic local_gate;
      logic ugt;
      logic sgt;
      logic zero;
   } cmie_psr_type;

   typedef struct packed {
      logic unlocked_only;
      logic dcache;
      logic icache;
   } cmie_cinv_type;

   typedef struct packed {
      logic valid;
      logic [3:0] vector;
      logic [23:0] ret_addr;
   } cmie_trap_type;
endpackage

// >>> cmie_exec.sv
// Purpose: executes address calc, cache invalidate, compare, irq gating and traps
// Assumes: one 100 MHz clock, AXI4-Lite register access, IRQ from a pin
// Notes: a write to CMD launches the command held in OPA/OPB/OPC
`include "cmie_defines.svh"
`timescale 1ns/100ps
`default_nettype none

// Contract
// - base pair plus zero-extended displacement, 24 bit
// - indexed base only from eight listed pairs
// - short absolute above limit ORs top segment
// - short absolute covers two windows
// - instruction and data cache options independent
// - unlocked option clears only unlocked lines
// - compare sets only three flags
// - zero flag set when sources equal
// - signed-greater flag on signed compare
// - unsigned-greater flag on unsigned compare
// - byte, word, doubleword compare widths
// - disable clears local gate
// - enable sets local gate, needs global
// - local gate changes two cycles later
// - enable-and-wait halts until interrupt
// - wait return address is next instruction
// - trap pushes its own address
// - reserved trap vector raises illegal opcode
// - only five vectors valid for trap
module cmie_exec (
   input wire logic CLK,
   input wire logic RST,
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic IRQ,
   output logic ICACHE_INV,
   output logic DCACHE_INV,
   output logic INV_UNLOCKED_ONLY,
   output logic IRQ_ACCEPT,
   output logic TRAP,
   output logic [3:0] TRAP_VECTOR,
   output logic [23:0] PUSH_ADDR,
   output logic HALTED
);

   logic aw_full_q, w_full_q, bvalid_q, rvalid_q;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q;
   logic do_write, do_read;
   logic [31:0] opa_q, opb_q, opc_q;
   logic [23:0] pc_q, result_q;
   logic [31:0] pc_merged;
   logic ea_err_q;
   cmie_pkg::cmie_psr_type psr_q;
   cmie_pkg::cmie_cinv_type cinv_q;
   cmie_pkg::cmie_trap_type trap_q;
   logic irq_meta_q, irq_sync_q;
   logic gate_pend_q, gate_val_q, gate_pend2_q, gate_val2_q;
   logic halted_q, accept_q;
   logic launch;
   logic [3:0] op;
   logic accept;
   logic [23:0] ea_d;
   logic ea_err_d;
   logic cmp_eq, cmp_sgt, cmp_ugt;

   // byte-lane merge for register writes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      return (a[1:0] == 2'h0) && (a <= `CMIE_OFF_PC);
   endfunction

   // ---------------- AXI4-Lite slave ----------------
   assign S_AXI_AWREADY = !aw_full_q && !bvalid_q;
   assign S_AXI_WREADY = !w_full_q && !bvalid_q;
   assign S_AXI_BVALID = bvalid_q;
   assign S_AXI_BRESP = bresp_q;
   assign S_AXI_ARREADY = !rvalid_q;
   assign S_AXI_RVALID = rvalid_q;
   assign S_AXI_RDATA = rdata_q;
   assign S_AXI_RRESP = rresp_q;
   assign do_write = aw_full_q && w_full_q && !bvalid_q;
   assign do_read = S_AXI_ARVALID && !rvalid_q;

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         aw_full_q <= 1'b0;
         aw_addr_q <= 8'h00;
      end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
         aw_full_q <= 1'b1;
         aw_addr_q <= S_AXI_AWADDR;
      end else if (do_write) begin
         aw_full_q <= 1'b0;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         w_full_q <= 1'b0;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
      end else if (S_AXI_WVALID && S_AXI_WREADY) begin
         w_full_q <= 1'b1;
         w_data_q <= S_AXI_WDATA;
         w_strb_q <= S_AXI_WSTRB;
      end else if (do_write) begin
         w_full_q <= 1'b0;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         bvalid_q <= 1'b0;
         bresp_q <= `CMIE_RESP_OKAY;
      end else if (do_write) begin
         bvalid_q <= 1'b1;
         bresp_q <= mapped(aw_addr_q) ? `CMIE_RESP_OKAY : `CMIE_RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
         bvalid_q <= 1'b0;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= `CMIE_RESP_OKAY;
      end else if (do_read) begin
         rvalid_q <= 1'b1;
         rresp_q <= mapped(S_AXI_ARADDR) ? `CMIE_RESP_OKAY : `CMIE_RESP_SLVERR;
         unique case (S_AXI_ARADDR)
            `CMIE_OFF_OPA: rdata_q <= opa_q;
            `CMIE_OFF_OPB: rdata_q <= opb_q;
            `CMIE_OFF_OPC: rdata_q <= opc_q;
            `CMIE_OFF_PSR: rdata_q <= {26'h0000000, psr_q};
            `CMIE_OFF_RESULT: rdata_q <= {8'h00, result_q};
            `CMIE_OFF_STATUS: rdata_q <= {30'h00000000, ea_err_q, halted_q};
            `CMIE_OFF_PC: rdata_q <= {8'h00, pc_q};
            default: rdata_q <= 32'h00000000;
         endcase
      end else if (S_AXI_RREADY) begin
         rvalid_q <= 1'b0;
      end
   end

   // ---------------- operand registers ----------------
   assign launch = do_write && (aw_addr_q == `CMIE_OFF_CMD) && w_strb_q[0];
   assign op = w_data_q[3:0];
   assign pc_merged = merge({8'h00, pc_q}, w_data_q, w_strb_q);

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         opa_q <= 32'h00000000;
         opb_q <= 32'h00000000;
         opc_q <= 32'h00000000;
         pc_q <= 24'h000000;
      end else if (do_write) begin
         if (aw_addr_q == `CMIE_OFF_OPA) begin
            opa_q <= merge(opa_q, w_data_q, w_strb_q);
         end
         if (aw_addr_q == `CMIE_OFF_OPB) begin
            opb_q <= merge(opb_q, w_data_q, w_strb_q);
         end
         if (aw_addr_q == `CMIE_OFF_OPC) begin
            opc_q <= merge(opc_q, w_data_q, w_strb_q);
         end
         if (aw_addr_q == `CMIE_OFF_PC) begin
            pc_q <= pc_merged[23:0];
         end
      end
   end

   // ---------------- effective address ----------------
   always_comb begin
      logic [23:0] disp;
      logic [3:0] pair;
      disp = opb_q[23:0] & (opc_q[`CMIE_OPC_DISP20] ? `CMIE_DISP20_MASK : `CMIE_DISP16_MASK);
      pair = opc_q[`CMIE_OPC_PAIR_LSB +: 4];
      ea_d = 24'h000000;
      ea_err_d = 1'b0;
      unique case (opc_q[`CMIE_OPC_MODE_LSB +: 3])
         `CMIE_MODE_RELRP: ea_d = opa_q[23:0] + disp;
         `CMIE_MODE_IDXRP: begin
            ea_err_d = psr_q.srcfg || !(pair inside {4'd0, 4'd2, 4'd4, 4'd6, 4'd8, 4'd10,
                                                     4'd3, 4'd5});
            if (!opc_q[`CMIE_OPC_DISP20]) begin
               disp = opb_q[23:0] & `CMIE_DISP14_MASK;
            end
            ea_d = opa_q[23:0] + {8'h00, opc_q[15:0]} + disp;
         end
         `CMIE_MODE_REL: begin
            if (!opc_q[`CMIE_OPC_DISP20]) begin
               disp = opb_q[23:0] & `CMIE_DISP14_MASK;
               ea_err_d = !psr_q.srcfg;
            end
            ea_d = {8'h00, opa_q[15:0]} + disp;
         end
         `CMIE_MODE_IDXABS: begin
            ea_err_d = psr_q.srcfg;
            ea_d = {8'h00, opc_q[15:0]} + (opb_q[23:0] & `CMIE_DISP20_MASK);
         end
         `CMIE_MODE_SHORT_ABSOLUTE: begin
            ea_d = opb_q[23:0] & `CMIE_DISP20_MASK;
            if (ea_d > `CMIE_SHORT_ABSOLUTE_LIMIT) begin
               ea_d = ea_d | `CMIE_TOP_SEGMENT;
            end
         end
         `CMIE_MODE_ABS24: ea_d = opb_q[23:0];
         default: ea_err_d = 1'b1;
      endcase
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         result_q <= 24'h000000;
         ea_err_q <= 1'b0;
      end else if (launch && op == `CMIE_OP_EA) begin
         result_q <= ea_d;
         ea_err_q <= ea_err_d;
      end
   end

   // ---------------- compare ----------------
   // width select: 0 byte, 1 word, 2+ doubleword
   always_comb begin
      logic [31:0] a, b;
      a = opa_q;
      b = opb_q;
      unique case (opc_q[1:0])
         2'h0: begin
            a = {{24{opa_q[7]}}, opa_q[7:0]};
            b = {{24{opb_q[7]}}, opb_q[7:0]};
         end
         2'h1: begin
            a = {{16{opa_q[15]}}, opa_q[15:0]};
            b = {{16{opb_q[15]}}, opb_q[15:0]};
         end
         default: begin
            a = opa_q;
            b = opb_q;
         end
      endcase
      cmp_eq = (a == b);
      cmp_sgt = $signed(a) > $signed(b);
      unique case (opc_q[1:0])
         2'h0: cmp_ugt = opa_q[7:0] > opb_q[7:0];
         2'h1: cmp_ugt = opa_q[15:0] > opb_q[15:0];
         default: cmp_ugt = opa_q > opb_q;
      endcase
   end

   // ---------------- PSR ----------------
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         psr_q <= '0;
      end else begin
         if (do_write && aw_addr_q == `CMIE_OFF_PSR && w_strb_q[0]) begin
            psr_q.zero <= w_data_q[`CMIE_PSR_ZERO];
            psr_q.sgt <= w_data_q[`CMIE_PSR_SGT];
            psr_q.ugt <= w_data_q[`CMIE_PSR_UGT];
            psr_q.global_gate <= w_data_q[`CMIE_PSR_GLOBAL];
            psr_q.srcfg <= w_data_q[`CMIE_PSR_SRCFG];
         end
         // only three flags, no result stored
         if (launch && op == `CMIE_OP_CMP) begin
            psr_q.zero <= cmp_eq;
            psr_q.sgt <= cmp_sgt;
            psr_q.ugt <= cmp_ugt;
         end
         // gate lands two cycles after the command
         if (accept) begin
            psr_q.local_gate <= 1'b0;
         end else if (gate_pend2_q) begin
            psr_q.local_gate <= gate_val2_q;
         end
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         gate_pend_q <= 1'b0;
         gate_val_q <= 1'b0;
         gate_pend2_q <= 1'b0;
         gate_val2_q <= 1'b0;
      end else begin
         // disable clears, enable and wait set
         gate_pend_q <= launch && (op == `CMIE_OP_DI || op == `CMIE_OP_EI ||
                                   op == `CMIE_OP_EIWAIT);
         gate_val_q <= (op != `CMIE_OP_DI);
         gate_pend2_q <= gate_pend_q;
         gate_val2_q <= gate_val_q;
      end
   end

   // ---------------- interrupt acceptance ----------------
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         irq_meta_q <= 1'b0;
         irq_sync_q <= 1'b0;
      end else begin
         irq_meta_q <= IRQ;
         irq_sync_q <= irq_meta_q;
      end
   end

   // local and global gate both needed
   assign accept = irq_sync_q && psr_q.local_gate && psr_q.global_gate;

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         halted_q <= 1'b0;
      end else if (accept) begin
         halted_q <= 1'b0;
      end else if (launch && op == `CMIE_OP_EIWAIT) begin
         halted_q <= 1'b1;
      end
   end

   // ---------------- traps, pushes and cache strobes ----------------
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         trap_q <= '0;
         accept_q <= 1'b0;
      end else begin
         trap_q.valid <= 1'b0;
         accept_q <= accept;
         if (accept) begin
            trap_q.ret_addr <= halted_q ? pc_q + `CMIE_EIWAIT_LEN : pc_q;
         end else if (launch && op == `CMIE_OP_EXCP) begin
            trap_q.valid <= 1'b1;
            trap_q.ret_addr <= pc_q;
            if (opa_q[3:0] inside {`CMIE_VEC_SVC, `CMIE_VEC_DVZ, `CMIE_VEC_FLG,
                                   `CMIE_VEC_BPT, `CMIE_VEC_UND}) begin
               trap_q.vector <= opa_q[3:0];
            end else begin
               trap_q.vector <= `CMIE_VEC_UND;
            end
         end
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         cinv_q <= '0;
      end else if (launch && op == `CMIE_OP_CINV) begin
         // independent options, none is a no-op
         cinv_q.icache <= opa_q[`CMIE_CINV_I];
         cinv_q.dcache <= opa_q[`CMIE_CINV_D];
         cinv_q.unlocked_only <= opa_q[`CMIE_CINV_U] &&
                                 (opa_q[`CMIE_CINV_I] || opa_q[`CMIE_CINV_D]);
      end else begin
         cinv_q <= '0;
      end
   end

   assign ICACHE_INV = cinv_q.icache;
   assign DCACHE_INV = cinv_q.dcache;
   assign INV_UNLOCKED_ONLY = cinv_q.unlocked_only;
   assign IRQ_ACCEPT = accept_q;
   assign TRAP = trap_q.valid;
   assign TRAP_VECTOR = trap_q.vector;
   assign PUSH_ADDR = trap_q.ret_addr;
   assign HALTED = halted_q;

endmodule
`default_nettype wire

// >>> cmie_monitor.sv
// Purpose: port checks for cmie_exec
// Assumes: one clock, async active-high reset
// Notes: bound to every cmie_exec
`timescale 1ns/100ps
`default_nettype none
module cmie_monitor (
   input wire logic CLK,
   input wire logic RST,
   input wire logic S_AXI_AWVALID,
   input wire logic S_AXI_AWREADY,
   input wire logic S_AXI_WVALID,
   input wire logic S_AXI_WREADY,
   input wire logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic IRQ,
   input wire logic ICACHE_INV,
   input wire logic DCACHE_INV,
   input wire logic INV_UNLOCKED_ONLY,
   input wire logic IRQ_ACCEPT,
   input wire logic TRAP,
   input wire logic [3:0] TRAP_VECTOR,
   input wire logic [23:0] PUSH_ADDR,
   input wire logic HALTED
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   sequence s_wr_take;
      S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
   endsequence
   sequence s_wake;
      $fell(HALTED);
   endsequence
   a_write_answer: assert property (s_wr_take |-> ##2 S_AXI_BVALID)
      else $error("write not answered");
   a_bvalid_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
      else $error("write response dropped");
   a_inv_pulse: assert property ((ICACHE_INV || DCACHE_INV) |=> !(ICACHE_INV || DCACHE_INV))
      else $error("invalidate longer than one cycle");
   a_unlocked_sel: assert property (INV_UNLOCKED_ONLY |-> (ICACHE_INV || DCACHE_INV))
      else $error("unlocked pulse without cache");
   a_trap_vector: assert property (TRAP |-> TRAP_VECTOR inside {4'h5, 4'h6, 4'h7, 4'h8, 4'hA})
      else $error("trap vector not legal");
   a_trap_pulse: assert property (TRAP |=> !TRAP)
      else $error("trap longer than one cycle");
   a_wake_accept: assert property (s_wake |-> IRQ_ACCEPT)
      else $error("halt left without interrupt");
   a_accept_push: assert property (IRQ_ACCEPT |-> !HALTED ##1 $stable(PUSH_ADDR))
      else $error("return address moved at accept");
   a_irq_cause: assert property (IRQ_ACCEPT |-> $past(IRQ, 3))
      else $error("accept without request");
   c_wake: cover property (s_wake);
endmodule
bind cmie_exec cmie_monitor cmie_monitor_i (.CLK, .RST, .S_AXI_AWVALID, .S_AXI_AWREADY,
   .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_BREADY, .IRQ, .ICACHE_INV,
   .DCACHE_INV, .INV_UNLOCKED_ONLY, .IRQ_ACCEPT, .TRAP, .TRAP_VECTOR, .PUSH_ADDR, .HALTED);
`default_nettype wire

// >>> cmie_far_model.sv
// Purpose: caches, request source and interrupt stack
// Assumes: pulses last one cycle
// Notes: request held until taken or withdrawn
`timescale 1ns/100ps
`default_nettype none
module cmie_far_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic icache_inv,
   input wire logic dcache_inv,
   input wire logic unlocked_only,
   input wire logic irq_accept,
   input wire logic trap,
   input wire logic [3:0] trap_vector,
   input wire logic [23:0] push_addr,
   input wire logic irq_req,
   output logic irq,
   output logic [3:0][7:0] cache_cnt,
   output logic [7:0] acc_cnt,
   output logic [7:0] trap_cnt,
   output logic [3:0] last_vec,
   output logic [23:0] last_push
);
   logic served_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq <= 1'b0;
         served_q <= 1'b0;
      end else begin
         served_q <= irq_req && (served_q || irq_accept);
         irq <= irq_req && !served_q && !irq_accept;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cache_cnt <= '0;
      end else begin
         if (icache_inv) cache_cnt[unlocked_only] <= cache_cnt[unlocked_only] + 8'h01;
         if (dcache_inv) cache_cnt[2 + unlocked_only] <= cache_cnt[2 + unlocked_only] + 8'h01;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         acc_cnt <= 8'h00;
         trap_cnt <= 8'h00;
         last_vec <= 4'h0;
         last_push <= 24'h000000;
      end else begin
         if (irq_accept) acc_cnt <= acc_cnt + 8'h01;
         if (trap) trap_cnt <= trap_cnt + 8'h01;
         if (trap) last_vec <= trap_vector;
         if (trap || irq_accept) last_push <= push_addr;
      end
   end
endmodule
`default_nettype wire

// >>> core_misc_instruction_exec_tb.sv
// Purpose: self-checking bench for cmie_exec
// Assumes: bus master over AXI4-Lite
// Notes: opcode 0 serves as no-op
`include "cmie_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module core_misc_instruction_exec_tb;
   logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
   logic irq_req = 1'b0, awrdy, wrdy, bv, arrdy, rv, icinv, dcinv, unl, acc, trap, halted, irq;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, accn, trapn, n0;
   logic [31:0] wdata = 32'h0, rdata, rd_q;
   logic [1:0] bresp, rresp, wresp_q, rresp_q;
   logic [3:0] tvec, lvec;
   logic [23:0] push, lpush;
   logic [3:0][7:0] cc, ecc;
   int bad_count = 0, checks_done = 0;
   localparam logic [31:0] EA_T [6][4] = '{
      '{32'h00FFFF00, 32'h00011234, 32'h00000000, 32'h001134},
      '{32'h00000010, 32'h000F1234, 32'h08000000, 32'h0F1244},
      '{32'h00001000, 32'h00004005, 32'h01030010, 32'h001015},
      '{32'h00000000, 32'h000F0001, 32'h04000000, 32'hFF0001},
      '{32'h00000000, 32'h000EFFFF, 32'h04000000, 32'h0EFFFF},
      '{32'h00000000, 32'h00ABCDEF, 32'h05000000, 32'hABCDEF}};
   localparam logic [31:0] CMP_T [6][4] = '{
      '{32'h80, 32'h7F, 0, 32'h4}, '{32'hFF05, 32'h05, 0, 32'h1},
      '{32'h1, 32'hFFFF, 1, 32'h2}, '{32'h80000000, 32'h1, 2, 32'h4},
      '{32'h12345678, 32'h12345678, 3, 32'h1}, '{32'h5, 32'h10005, 1, 32'h1}};
   always #5 clk = ~clk;
   cmie_exec cmie_exec_i (.CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv),
      .S_AXI_AWREADY(awrdy), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
      .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(brdy),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arrdy), .S_AXI_RDATA(rdata),
      .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rrdy), .IRQ(irq),
      .ICACHE_INV(icinv), .DCACHE_INV(dcinv), .INV_UNLOCKED_ONLY(unl), .IRQ_ACCEPT(acc),
      .TRAP(trap), .TRAP_VECTOR(tvec), .PUSH_ADDR(push), .HALTED(halted));
   cmie_far_model cmie_far_model_i (.clk(clk), .rst(rst), .icache_inv(icinv),
      .dcache_inv(dcinv), .unlocked_only(unl), .irq_accept(acc), .trap(trap),
      .trap_vector(tvec), .push_addr(push), .irq_req(irq_req), .irq(irq), .cache_cnt(cc),
      .acc_cnt(accn), .trap_cnt(trapn), .last_vec(lvec), .last_push(lpush));
   task automatic print_verdict();
      $display("checks %0d errors %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic guard(input int n);
      if (n > 200) begin
         bad_count++;
         $display("ERROR %0t wait ran out", $time);
         print_verdict();
      end
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      checks_done++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bit da, dw, ta, tw, got;
      int n;
      da = 0; dw = 0; got = 0; n = 0;
      @(posedge clk); awv <= 1'b1; wv <= 1'b1; awaddr <= a; wdata <= d;
      while (!(da && dw)) begin
         @(negedge clk); ta = !da && awrdy === 1'b1; tw = !dw && wrdy === 1'b1; n++; guard(n);
         @(posedge clk);
         if (ta) begin awv <= 1'b0; da = 1; end
         if (tw) begin wv <= 1'b0; dw = 1; end
      end
      brdy <= 1'b1;
      while (!got) begin
         @(negedge clk); got = bv === 1'b1; wresp_q = bresp; n++; guard(n);
         @(posedge clk);
      end
      brdy <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      bit da, ta, got;
      int n;
      da = 0; got = 0; n = 0;
      @(posedge clk); arv <= 1'b1; araddr <= a; rrdy <= 1'b1;
      while (!got) begin
         @(negedge clk); ta = !da && arrdy === 1'b1; got = rv === 1'b1; n++; guard(n);
         rd_q = rdata; rresp_q = rresp;
         @(posedge clk);
         if (ta) begin arv <= 1'b0; da = 1; end
      end
      rrdy <= 1'b0;
   endtask
   task automatic cmd(input logic [3:0] op);
      wr(`CMIE_OFF_CMD, {28'h0, op});
   endtask
   task automatic wait_cnt(input bit use_trap);
      int n;
      n = 0;
      while ((use_trap ? trapn : accn) === n0) begin @(negedge clk); n++; guard(n); end
   endtask
   task automatic t_regs();
      rd(`CMIE_OFF_PSR); chk(rd_q, 32'h0, "psr reset");
      rd(8'h20); chk(rresp_q, `CMIE_RESP_SLVERR, "unmapped read");
      wr(8'h22, 32'h1); chk(wresp_q, `CMIE_RESP_SLVERR, "misaligned write");
   endtask
   task automatic t_ea();
      for (int i = 0; i < 22; i++) begin
         wr(`CMIE_OFF_OPA, i < 6 ? EA_T[i][0] : 32'h1000);
         wr(`CMIE_OFF_OPB, i < 6 ? EA_T[i][1] : 32'h5);
         wr(`CMIE_OFF_OPC, i < 6 ? EA_T[i][2] : 32'h01000000 | ((i - 6) << 16));
         cmd(`CMIE_OP_EA);
         rd(`CMIE_OFF_STATUS);
         chk(rd_q[1], i >= 6 && !((i - 6) inside {0, 2, 4, 6, 8, 10, 3, 5}), "ea error");
         rd(`CMIE_OFF_RESULT);
         if (i < 6) chk(rd_q[23:0], EA_T[i][3], "ea result");
      end
   endtask
   task automatic t_cmp();
      wr(`CMIE_OFF_PSR, 32'h10);
      for (int i = 0; i < 6; i++) begin
         wr(`CMIE_OFF_OPA, CMP_T[i][0]);
         wr(`CMIE_OFF_OPB, CMP_T[i][1]);
         wr(`CMIE_OFF_OPC, CMP_T[i][2]);
         cmd(`CMIE_OP_CMP);
         rd(`CMIE_OFF_PSR);
         chk(rd_q[4:0], 32'h10 | CMP_T[i][3], "compare flags");
      end
   endtask
   task automatic t_cinv();
      ecc = '0;
      for (int o = 0; o < 8; o++) begin
         wr(`CMIE_OFF_OPA, o);
         cmd(`CMIE_OP_CINV);
         if (o[0]) ecc[o[2]] = ecc[o[2]] + 8'h01;
         if (o[1]) ecc[2 + o[2]] = ecc[2 + o[2]] + 8'h01;
         @(negedge clk);
         chk(cc, ecc, "cache invalidates");
      end
   endtask
   task automatic t_irq();
      wr(`CMIE_OFF_PSR, 32'h10); wr(`CMIE_OFF_PC, 32'h100);
      @(posedge clk) irq_req <= 1'b1;
      n0 = accn; cmd(4'h5);
      @(negedge clk); chk(acc, 1'b0, "accept before gate");
      wait_cnt(1'b0); chk(lpush, 24'h100, "accept push");
      @(posedge clk) irq_req <= 1'b0;
      rd(`CMIE_OFF_PSR); chk(rd_q[3], 1'b0, "gate after accept");
      cmd(4'h5); cmd(4'h0);
      rd(`CMIE_OFF_PSR); chk(rd_q[3], 1'b1, "gate on");
      cmd(4'h4); cmd(4'h0);
      rd(`CMIE_OFF_PSR); chk(rd_q[3], 1'b0, "gate off");
      n0 = accn; @(posedge clk) irq_req <= 1'b1;
      repeat (20) @(posedge clk);
      chk(accn, n0, "masked accept");
      wr(`CMIE_OFF_PSR, 32'h0); cmd(4'h5); cmd(4'h0);
      repeat (20) @(posedge clk);
      chk(accn, n0, "global gate accept");
      irq_req <= 1'b0;
      cmd(4'h4); cmd(4'h0);
      wr(`CMIE_OFF_PSR, 32'h10); wr(`CMIE_OFF_PC, 32'h200);
      cmd(4'h6);
      repeat (6) @(posedge clk);
      @(negedge clk); chk(halted, 1'b1, "halt held");
      n0 = accn; @(posedge clk) irq_req <= 1'b1;
      wait_cnt(1'b0);
      chk(lpush, 24'h200 + `CMIE_EIWAIT_LEN, "wait push");
      chk(halted, 1'b0, "halt left");
      @(posedge clk) irq_req <= 1'b0;
   endtask
   task automatic t_trap();
      wr(`CMIE_OFF_PC, 32'h345);
      for (int v = 0; v < 16; v++) begin
         wr(`CMIE_OFF_OPA, v);
         n0 = trapn; cmd(`CMIE_OP_EXCP); wait_cnt(1'b1);
         chk(lvec, v inside {5, 6, 7, 8, 10} ? v : 4'hA, "trap vector");
         chk(lpush, 24'h345, "trap push");
      end
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      t_regs(); t_ea(); t_cmp(); t_cinv(); t_irq(); t_trap();
      print_verdict();
   end
endmodule
`default_nettype wire
